/* File: byte_fifo.sv */
// Shared byte FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo
  import epp_port_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  // Flags
  output logic                  full,
  output logic                  empty
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  // Handshakes from the occupancy count
  assign full     = (count_reg == CW'(DEPTH));
  assign empty    = (count_reg == '0);
  assign inReady  = !full;
  assign outValid = !empty;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_reg[rdPtr_reg];

  // Storage, no reset needed on the data
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
    end
  end

  // Occupancy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  a_fifo_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    push && !pop |=> count_reg == $past(count_reg) + 1'b1)
    else $error("fifo count did not rise on push");

endmodule

/* File: epp_peripheral_model.sv */
// Behavioural EPP peripheral facing the port's parallel pins
`timescale 1ns/1ps
module epp_peripheral_model (
  // Clock
  input  wire logic       clk_sys,
  // Port pins
  input  wire logic [7:0] pdOut,
  input  wire logic       pdOe_n,
  input  wire logic       writeLine_n,
  input  wire logic       dataPhaseStrobe_n,
  input  wire logic       addrPhaseStrobe_n,
  output logic      [7:0] pdIn,
  output logic            peripheralHold_n,
  // Bench controls
  input  wire logic [3:0] holdDelay,
  input  wire logic       stuck,
  input  wire logic [7:0] readByte,
  output logic      [7:0] gotByte,
  output logic            gotAddr
);
  logic [7:0] drive;
  logic       holdReg;

  // Wire level; a released bus shows the inverse, never the old byte
  assign pdIn = pdOe_n ? drive : pdOut;
  // A stuck peripheral never acknowledges
  assign peripheralHold_n = holdReg & ~stuck;

  ////////////////////////////////////////////////////////////////////////
  // One handshake per strobe; idle hold low means ready
  // Falling edge only, so pins never move on the port's sampling edge
  initial begin
    drive = 8'h5A;
    holdReg = 1'b0;
    gotByte = 8'h00;
    gotAddr = 1'b0;
    forever begin
      @(negedge clk_sys);
      if (!dataPhaseStrobe_n || !addrPhaseStrobe_n) begin
        gotAddr = !addrPhaseStrobe_n;
        repeat (holdDelay) @(negedge clk_sys);
        if (writeLine_n) begin
          drive = readByte;
        end else begin
          gotByte = pdOut;
        end
        repeat (5) @(negedge clk_sys);
        holdReg = 1'b1;
        while (!dataPhaseStrobe_n || !addrPhaseStrobe_n) @(negedge clk_sys);
        drive = ~drive;
        repeat (2) @(negedge clk_sys);
        holdReg = 1'b0;
      end
    end
  end
endmodule

/* File: epp_port_core.sv */
// EPP 1.7 cycle engine, port registers and shared FIFO views
`timescale 1ns/1ps
module epp_port_core
  import epp_port_pkg::*;
#(
  parameter int TimeoutCycles = TIMEOUT_CYC,
  parameter int FifoDepth     = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Host I/O port
  input  wire logic [10:0] ioAddr,
  input  wire logic        ioWr,
  input  wire logic        ioRd,
  input  wire logic [7:0]  ioWData,
  output logic      [7:0]  ioRData,
  output logic             ioDone,
  // Configuration selections
  input  wire logic [2:0]  cfgIrqSel,
  input  wire logic [2:0]  cfgDmaSel,
  // Parallel bus
  input  wire logic [7:0]  pdIn,
  output logic      [7:0]  pdOut,
  output logic             pdOe_n,
  // EPP handshake
  output logic             writeLine_n,
  output logic             dataPhaseStrobe_n,
  output logic             addrPhaseStrobe_n,
  input  wire logic        peripheralHold_n,
  // Peripheral status and control
  input  wire logic        peripheralInterruptIn,
  input  wire logic        busyIn,
  input  wire logic        paperEndIn,
  input  wire logic        selectIn,
  input  wire logic        faultIn_n,
  output logic             peripheralReset_n,
  output logic             irqOut
);

  // Settle: take a new level only when the two late stages agree
  function automatic logic [7:0] settle(input logic [7:0] old,
                                        input logic [7:0] s2,
                                        input logic [7:0] s3);
    logic [7:0] r;
    r = old;
    for (int i = 0; i < 8; i++) begin
      if (s2[i] == s3[i]) begin
        r[i] = s3[i];
      end
    end
    return r;
  endfunction

  localparam int TW = $clog2(TimeoutCycles + 1);

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [7:0] pinS1_reg, pinS2_reg, pinS3_reg, pinLvl_reg;
  logic [7:0] pdS1_reg, pdS2_reg, pdS3_reg, pdLvl_reg;
  logic       holdHigh, intrLvl, busyLvl;

  // Three stages each; stage one feeds only stage two
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pinS1_reg  <= 8'h00;
      pinS2_reg  <= 8'h00;
      pinS3_reg  <= 8'h00;
      pinLvl_reg <= 8'h00;
    end else begin
      pinS1_reg  <= {3'h0, faultIn_n, selectIn, paperEndIn, busyIn,
                     peripheralInterruptIn ^ 1'b0} |
                    {2'h0, peripheralHold_n, 5'h00};
      pinS2_reg  <= pinS1_reg;
      pinS3_reg  <= pinS2_reg;
      pinLvl_reg <= settle(pinLvl_reg, pinS2_reg, pinS3_reg);
    end
  end

  // Data pins sampled the same way for reads
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pdS1_reg  <= 8'h00;
      pdS2_reg  <= 8'h00;
      pdS3_reg  <= 8'h00;
      pdLvl_reg <= 8'h00;
    end else begin
      pdS1_reg  <= pdIn;
      pdS2_reg  <= pdS1_reg;
      pdS3_reg  <= pdS2_reg;
      pdLvl_reg <= settle(pdLvl_reg, pdS2_reg, pdS3_reg);
    end
  end

  assign holdHigh = pinLvl_reg[5];
  assign intrLvl  = pinLvl_reg[0];
  assign busyLvl  = pinLvl_reg[1];

  //////////////////////////////////////////////////////////////////////
  // Registers and request capture

  logic [7:0]  ctrl_reg;
  logic [5:0]  ext_reg;
  logic        timeout_reg;
  logic [7:0]  pdOut_reg;
  logic        reqActive_reg, reqWrite_reg;
  logic [10:0] reqAddr_reg;
  logic [7:0]  reqWData_reg;
  logic [7:0]  ioRData_reg;
  logic        ioDone_reg;
  mode_t       mode;
  logic        isEpp, isFifoWr, isFifoRd, finish, plainWr, tmoClear;
  logic        fifoInReady, fifoOutValid, fifoOutReady, fifoFull;
  logic        fifoEmpty, drain;
  logic [8:0]  fifoOutData;

  assign mode = mode_t'(ext_reg[5:3]);

  // EPP registers exist only in EPP mode; FIFO views decode only in their own modes
  assign isEpp = (mode == MODE_EPP) && (reqAddr_reg >= OFS_EPP_ADDR) &&
                 (reqAddr_reg <= OFS_EPP_LAST);
  // Every FIFO view lands in the one shared FIFO
  assign isFifoWr = reqWrite_reg &&
    ((reqAddr_reg == OFS_FIFO && (mode == MODE_FIFO ||
      mode == MODE_ECP || mode == MODE_TEST)) ||
     (reqAddr_reg == OFS_DATA && mode == MODE_ECP));
  assign isFifoRd = !reqWrite_reg && reqAddr_reg == OFS_FIFO &&
                    mode == MODE_TEST;

  // Accept one request at a time, hold it until it finishes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reqActive_reg <= 1'b0;
      reqWrite_reg  <= 1'b0;
      reqAddr_reg   <= 11'h000;
      reqWData_reg  <= 8'h00;
    end else if (!reqActive_reg && (ioWr || ioRd)) begin
      reqActive_reg <= 1'b1;
      reqWrite_reg  <= ioWr;
      reqAddr_reg   <= ioAddr;
      reqWData_reg  <= ioWData;
    end else if (finish) begin
      reqActive_reg <= 1'b0;
    end
  end

  assign plainWr  = finish && reqWrite_reg && !isEpp && !isFifoWr;
  assign tmoClear = plainWr && reqAddr_reg == OFS_STATUS &&
                    reqWData_reg[STS_TIMEOUT];

  // Control and extended control; control writes work in any mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= CONTROL_RST;
      ext_reg  <= EXT_RST;
    end else if (plainWr) begin
      if (reqAddr_reg == OFS_CONTROL) begin
        ctrl_reg <= {2'h0, reqWData_reg[5:0]};
      end
      if (reqAddr_reg == OFS_EXT_CTRL) begin
        ext_reg <= reqWData_reg[7:2];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // EPP 1.7 cycle sequencer

  epp_state_t      state_reg;
  logic [TW-1:0]   timer_reg;
  logic            eppWrite_reg, eppIsAddr_reg, timedOut;
  logic [7:0]      eppRead_reg;

  assign timedOut = (timer_reg >= TW'(TimeoutCycles));

  // One setup cycle, strobe until hold rises or the watchdog fires
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (reqActive_reg && isEpp) begin
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP:  state_reg <= ST_STROBE;
        ST_STROBE: begin
          if (holdHigh || timedOut) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE:   state_reg <= ST_IDLE;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  // Watchdog runs from cycle start until the sequencer returns to idle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      timer_reg <= '0;
    end else if (!timedOut) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // Direction frozen at cycle start; a set strobe bit forces write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eppWrite_reg  <= 1'b0;
      eppIsAddr_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && reqActive_reg && isEpp) begin
      eppWrite_reg  <= (reqWrite_reg && !ctrl_reg[CTL_DIR]) ||
                       ctrl_reg[CTL_STROBE];
      eppIsAddr_reg <= (reqAddr_reg == OFS_EPP_ADDR);
    end
  end

  // Read byte captured in the last strobe cycle, as the strobe is removed; valid once hold is high
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eppRead_reg <= 8'h00;
    end else if (state_reg == ST_STROBE && (holdHigh || timedOut)) begin
      eppRead_reg <= pdLvl_reg;
    end
  end

  // Watchdog flag, set wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timeout_reg <= 1'b0;
    end else if (state_reg == ST_STROBE && timedOut && !holdHigh) begin
      timeout_reg <= 1'b1;
    end else if (tmoClear) begin
      timeout_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Shared FIFO and forward drain

  // Drain forward only while the peripheral is not busy
  assign drain = (mode == MODE_FIFO || mode == MODE_ECP) && !busyLvl &&
                 state_reg == ST_IDLE;
  assign fifoOutReady = drain || (reqActive_reg && isFifoRd);

  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FifoDepth)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (reqActive_reg && isFifoWr),
    .inReady  (fifoInReady),
    .inData   ({reqAddr_reg == OFS_DATA, reqWData_reg}),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData),
    .full     (fifoFull),
    .empty    (fifoEmpty)
  );

  // Full FIFO holds the host in wait states until space opens
  always_comb begin
    finish = 1'b0;
    if (reqActive_reg) begin
      if (isEpp) begin
        finish = (state_reg == ST_DONE);
      end else if (isFifoWr) begin
        finish = fifoInReady;
      end else begin
        finish = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Parallel bus drive

  // Byte held after a write cycle until something replaces it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pdOut_reg <= DATA_RST;
    end else if (state_reg == ST_IDLE && reqActive_reg && isEpp &&
                 reqWrite_reg) begin
      pdOut_reg <= reqWData_reg;
    end else if (plainWr && reqAddr_reg == OFS_DATA) begin
      pdOut_reg <= reqWData_reg;
    end else if (drain && fifoOutValid) begin
      pdOut_reg <= fifoOutData[7:0];
    end
  end

  assign pdOut = pdOut_reg;
  // Drivers off for EPP reads, on for EPP writes; outside a cycle the direction bit decides
  assign pdOe_n = (state_reg != ST_IDLE) ? !eppWrite_reg :
                  ctrl_reg[CTL_DIR];
  assign writeLine_n = (state_reg != ST_IDLE) ? !eppWrite_reg :
                       ctrl_reg[CTL_DIR];
  assign dataPhaseStrobe_n = !(state_reg == ST_STROBE && !eppIsAddr_reg);
  assign addrPhaseStrobe_n = !(state_reg == ST_STROBE && eppIsAddr_reg);
  assign peripheralReset_n = ctrl_reg[CTL_INIT];
  assign irqOut = intrLvl && ctrl_reg[CTL_ACKINT];

  //////////////////////////////////////////////////////////////////////
  // Host read data and completion

  logic [7:0] rdMux;

  // Read mux; compression bit reads zero, not implemented
  always_comb begin
    rdMux = 8'h00;
    case (reqAddr_reg)
      OFS_DATA:     rdMux = ctrl_reg[CTL_DIR] ? pdLvl_reg : pdOut_reg;
      OFS_STATUS:   rdMux = {!busyLvl, intrLvl, pinLvl_reg[2],
                             pinLvl_reg[3], pinLvl_reg[4], 2'h0,
                             timeout_reg};
      OFS_CONTROL:  rdMux = ctrl_reg;
      OFS_CFG_A:    rdMux = (mode == MODE_CONFIG) ? CFG_A_VALUE :
                            (fifoOutValid ? fifoOutData[7:0] : 8'h00);
      OFS_CFG_B:    rdMux = {1'b0, intrLvl, cfgIrqSel, cfgDmaSel};
      OFS_EXT_CTRL: rdMux = {ext_reg, fifoFull, fifoEmpty};
      default:      rdMux = 8'h00;
    endcase
    if (isEpp) begin
      rdMux = eppRead_reg;
    end
  end

  // Completion pulse with its data one cycle after finish
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ioDone_reg  <= 1'b0;
      ioRData_reg <= 8'h00;
    end else begin
      ioDone_reg <= finish;
      if (finish && !reqWrite_reg) begin
        ioRData_reg <= rdMux;
      end
    end
  end

  assign ioDone  = ioDone_reg;
  assign ioRData = ioRData_reg;

  //////////////////////////////////////////////////////////////////////
  // Checks

  a_strobe_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(!dataPhaseStrobe_n && !addrPhaseStrobe_n))
    else $error("both strobes asserted");

  a_write_byte_first: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(dataPhaseStrobe_n) && eppWrite_reg |->
      !pdOe_n && !$past(pdOe_n) && pdOut == $past(pdOut))
    else $error("write strobe before byte settled");

  a_hold_stretch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == ST_STROBE && !holdHigh && !timedOut |=>
      state_reg == ST_STROBE && !ioDone)
    else $error("cycle ended while hold low");

  a_end_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == ST_STROBE && holdHigh |=>
      dataPhaseStrobe_n && addrPhaseStrobe_n ##1 ioDone)
    else $error("cycle end sequence wrong");

  a_read_bus_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!dataPhaseStrobe_n || !addrPhaseStrobe_n) && !eppWrite_reg |->
      pdOe_n && writeLine_n)
    else $error("bus driven during read strobe");

  a_watchdog_abort: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == ST_SETUP && !holdHigh |->
      ##[1:250] state_reg == ST_DONE)
    else $error("cycle not aborted by watchdog");

  a_timeout_sticky: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    timeout_reg && !tmoClear |=> timeout_reg)
    else $error("timeout flag lost");

  a_status_any_mode: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !reqActive_reg && ioRd && !ioWr && ioAddr == OFS_STATUS |=>
      ##1 ioDone)
    else $error("status read not answered");

  a_irq_through: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(intrLvl) && ctrl_reg[CTL_ACKINT] |-> irqOut)
    else $error("interrupt not passed through");

  a_reset_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    plainWr && reqAddr_reg == OFS_CONTROL && !reqWData_reg[CTL_INIT]
      |=> !peripheralReset_n)
    else $error("reset output not asserted");

  a_override_write: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state_reg == ST_SETUP && ctrl_reg[CTL_STROBE] |-> !writeLine_n)
    else $error("strobe bit did not force write");

  c_epp_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == ST_DONE && eppWrite_reg);
  c_epp_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == ST_DONE && !eppWrite_reg && !timeout_reg);
  c_timeout: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(timeout_reg));
  c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_n)
    fifoFull && reqActive_reg && isFifoWr);

endmodule

/* File: epp_port_pkg.sv */
// Constants, register map and types for the EPP/ECP parallel port
package epp_port_pkg;

  // Timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int EPP_TIMEOUT_NS = 10000;
  localparam int TIMEOUT_CYC    = EPP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH     = 16;
  localparam int FIFO_WIDTH     = 9;

  // Register offsets from the port base
  localparam logic [10:0] OFS_DATA     = 11'h000;
  localparam logic [10:0] OFS_STATUS   = 11'h001;
  localparam logic [10:0] OFS_CONTROL  = 11'h002;
  localparam logic [10:0] OFS_EPP_ADDR = 11'h003;
  localparam logic [10:0] OFS_EPP_LAST = 11'h007;
  localparam logic [10:0] OFS_FIFO     = 11'h400;
  localparam logic [10:0] OFS_CFG_A    = 11'h400;
  localparam logic [10:0] OFS_CFG_B    = 11'h401;
  localparam logic [10:0] OFS_EXT_CTRL = 11'h402;

  // Control register fields
  localparam int CTL_STROBE  = 0;
  localparam int CTL_AUTOFD  = 1;
  localparam int CTL_INIT    = 2;
  localparam int CTL_SELIN   = 3;
  localparam int CTL_ACKINT  = 4;
  localparam int CTL_DIR     = 5;
  localparam int STS_TIMEOUT = 0;

  // Reset and fixed values
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [5:0] EXT_RST     = 6'h00;
  localparam logic [7:0] CFG_A_VALUE = 8'h10;

  // Port modes, extended control bits 7:5
  typedef enum logic [2:0] {
    MODE_SPP    = 3'h0,
    MODE_PS2    = 3'h1,
    MODE_FIFO   = 3'h2,
    MODE_ECP    = 3'h3,
    MODE_EPP    = 3'h4,
    MODE_TEST   = 3'h6,
    MODE_CONFIG = 3'h7
  } mode_t;

  // EPP cycle sequencer
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_DONE   = 4'h8
  } epp_state_t;

endpackage

/* File: testbench.sv */
// Self-checking bench for the EPP/ECP port core
`timescale 1ns/1ps
module testbench;
  import epp_port_pkg::*;
  logic        clk_sys, rst_n, ioWr, ioRd, ioDone, irqOut, intIn;
  logic        pdOe_n, wrN, dsN, asN, holdN, rstOut_n, stuck, gotAddr;
  logic        busy, sel;
  logic [10:0] ioAddr, a;
  logic [7:0]  ioWData, ioRData, pdIn, pdOut, readByte, gotByte, d;
  logic [2:0]  irqSel, dmaSel;
  logic [3:0]  holdDelay;
  logic [16:0] e;
  logic [16:0] expQ[$];
  logic [7:0]  fifoData[16];
  int          num_errors, cmp_count;

  epp_port_core #(.TimeoutCycles(TIMEOUT_CYC), .FifoDepth(FIFO_DEPTH)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ioAddr(ioAddr), .ioWr(ioWr),
    .ioRd(ioRd), .ioWData(ioWData), .ioRData(ioRData), .ioDone(ioDone),
    .cfgIrqSel(irqSel), .cfgDmaSel(dmaSel), .pdIn(pdIn), .pdOut(pdOut),
    .pdOe_n(pdOe_n), .writeLine_n(wrN), .dataPhaseStrobe_n(dsN),
    .addrPhaseStrobe_n(asN), .peripheralHold_n(holdN),
    .peripheralInterruptIn(intIn), .busyIn(busy), .paperEndIn(1'b0),
    .selectIn(sel), .faultIn_n(1'b1), .peripheralReset_n(rstOut_n),
    .irqOut(irqOut));

  epp_peripheral_model i_model (
    .clk_sys(clk_sys), .pdOut(pdOut), .pdOe_n(pdOe_n), .writeLine_n(wrN),
    .dataPhaseStrobe_n(dsN), .addrPhaseStrobe_n(asN), .pdIn(pdIn),
    .peripheralHold_n(holdN), .holdDelay(holdDelay), .stuck(stuck),
    .readByte(readByte), .gotByte(gotByte), .gotAddr(gotAddr));

  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One-cycle request pulse; note the expectation, wait for completion
  task automatic io(input logic rd, input logic [10:0] ad,
                    input logic [7:0] dv, input logic [7:0] m);
    int n;
    @(negedge clk_sys);
    expQ.push_back({rd, m, dv});
    ioAddr = ad;
    ioWData = dv;
    ioRd = rd;
    ioWr = !rd;
    @(negedge clk_sys);
    ioRd = 1'b0;
    ioWr = 1'b0;
    n = 0;
    // Aborted EPP cycles need the full watchdog span, so allow 300
    while (ioDone !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300) begin
      num_errors++;
      $display("unexpected hang at %0t: %h %h", $time, ad, dv);
      conclude();
    end
  endtask

  // Completion watcher; read data is sampled in the done cycle and held until the next read
  always @(negedge clk_sys) begin
    if (ioDone === 1'b1) begin
      e = expQ.pop_front();
      if (e[16]) chk(ioRData & e[15:8], e[7:0] & e[15:8]);
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(50 * 20000);
    num_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, ioWr, ioRd, intIn, stuck, busy, sel} = '0;
    {ioAddr, ioWData, readByte, irqSel, dmaSel, holdDelay} = '0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'hd04d467f));
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk({7'h00, rstOut_n}, 8'h00);
    io(1'b0, OFS_CONTROL, 8'h14, 8'h00);
    intIn = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk({7'h00, irqOut}, 8'h01);
    chk({7'h00, rstOut_n}, 8'h01);
    io(1'b0, OFS_EXT_CTRL, 8'h80, 8'h00);
    io(1'b1, OFS_CONTROL, 8'h14, 8'hFF);
    // Address and data ports with short and long hold phases
    for (int k = 0; k < 4; k++) begin
      holdDelay = 4'(k * 5);
      a = k[0] ? OFS_EPP_ADDR : OFS_EPP_ADDR + 11'(k + 1);
      d = 8'($urandom);
      io(1'b0, OFS_CONTROL, 8'h04, 8'h00);
      io(1'b0, a, d, 8'h00);
      chk(gotByte, d);
      chk({7'h00, gotAddr}, {7'h00, k[0]});
      readByte = 8'($urandom);
      io(1'b0, OFS_CONTROL, 8'h24, 8'h00);
      io(1'b1, a, readByte, 8'hFF);
    end
    // Peripheral never releases hold: cycle must abort
    holdDelay = 4'h0;
    stuck = 1'b1;
    io(1'b0, OFS_CONTROL, 8'h04, 8'h00);
    io(1'b0, OFS_EPP_LAST, 8'hA5, 8'h00);
    chk({7'h00, irqOut}, 8'h00);
    stuck = 1'b0;
    busy = 1'($urandom);
    sel = 1'($urandom);
    repeat (12) @(negedge clk_sys);
    io(1'b1, OFS_STATUS, {~busy, 2'h2, sel, 4'h9}, 8'hFF);
    io(1'b1, OFS_STATUS, 8'h01, 8'h01);
    io(1'b0, OFS_STATUS, 8'h01, 8'h00);
    io(1'b1, OFS_STATUS, 8'h00, 8'h01);
    // Set strobe bit turns a read into a write of the held byte
    readByte = 8'h3C;
    io(1'b0, OFS_CONTROL, 8'h25, 8'h00);
    io(1'b1, OFS_EPP_ADDR, 8'hA5, 8'hFF);
    irqSel = 3'($urandom);
    dmaSel = 3'($urandom);
    io(1'b1, OFS_CFG_B, {2'b00, irqSel, dmaSel}, 8'hBF);
    io(1'b0, OFS_EXT_CTRL, 8'hE0, 8'h00);
    io(1'b1, OFS_CFG_A, CFG_A_VALUE, 8'hFF);
    // Fill the shared FIFO through its test view, then drain it
    io(1'b0, OFS_EXT_CTRL, 8'hC0, 8'h00);
    for (int i = 0; i < 16; i++) begin
      fifoData[i] = 8'($urandom);
      io(1'b0, OFS_FIFO, fifoData[i], 8'h00);
    end
    io(1'b1, OFS_EXT_CTRL, 8'h02, 8'h03);
    for (int i = 0; i < 16; i++) begin
      io(1'b1, OFS_FIFO, fifoData[i], 8'hFF);
    end
    io(1'b1, OFS_EXT_CTRL, 8'h01, 8'h03);
    // Forward drain held off while busy, then the byte reaches the bus
    busy = 1'b1;
    io(1'b0, OFS_CONTROL, 8'h04, 8'h00);
    io(1'b0, OFS_EXT_CTRL, 8'h40, 8'h00);
    repeat (6) @(negedge clk_sys);
    d = 8'($urandom);
    io(1'b0, OFS_FIFO, d, 8'h00);
    io(1'b1, OFS_EXT_CTRL, 8'h40, 8'hFF);
    busy = 1'b0;
    repeat (6) @(negedge clk_sys);
    io(1'b1, OFS_DATA, d, 8'hFF);
    // Address view of the same FIFO in the ECP mode
    io(1'b0, OFS_EXT_CTRL, 8'h60, 8'h00);
    d = ~d;
    io(1'b0, OFS_DATA, d, 8'h00);
    io(1'b1, OFS_DATA, d, 8'hFF);
    repeat (4) @(negedge clk_sys);
    conclude();
  end
endmodule
